// file: pkg/psg_pkg.sv
package psg_pkg;
  localparam logic [19:0] PSG_ADDR_PINS01 = 20'h40850;
  localparam logic [19:0] PSG_ADDR_PINS23 = 20'h40854;
  localparam logic [19:0] PSG_ADDR_PINS45 = 20'h40858;
  localparam logic [19:0] PSG_ADDR_PINS67 = 20'h4085C;
  localparam logic [19:0] PSG_ADDR_LCDMODE = 20'h41B04;
  localparam int PSG_LO_FIELD = 0;
  localparam int PSG_HI_FIELD = 16;
  localparam int PSG_OE_BIT = 3;
  localparam int PSG_IE_BIT = 2;
  localparam int PSG_DO_BIT = 1;
  localparam int PSG_DI_BIT = 0;
  localparam logic [7:0] PSG_SEG_RESET = 8'h00;
  localparam logic [2:0] PSG_DUTY_RESET = 3'h0;
  localparam logic [1:0] PSG_RESP_OKAY = 2'h0;
  localparam logic [1:0] PSG_RESP_SLVERR = 2'h2;
  localparam int PSG_PINS = 8;

  typedef struct packed {
    logic oe;
    logic ie;
    logic lvl;
  } psg_pin_cfg_t;

  typedef struct packed {
    logic        seg_mode;
    logic [2:0]  duty;
  } psg_lcd_cfg_t;
endpackage : psg_pkg

// file: design/psg_pin.sv
`timescale 1ns/1ps
`default_nettype none
// One port pin: driver control, synchronised gated input
module psg_pin
  import psg_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic seg_mode,
  input  wire logic seg_level,
  input  wire psg_pin_cfg_t cfg,
  input  wire logic pad_i,
  output logic      pad_o,
  output logic      pad_oe,
  output logic      state
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic o;
    logic oe;
    logic st;
  } psg_pin_st_t;
  psg_pin_st_t st_r;
  psg_pin_st_t st_nxt;

  // Segment view drives glass always; pin view follows its bits
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pad_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.oe = seg_mode | cfg.oe;
    st_nxt.o  = seg_mode ? seg_level : cfg.lvl;
    st_nxt.st = cfg.ie & st_r.s2;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pad_o  = st_r.o;
  assign pad_oe = st_r.oe;
  assign state  = st_r.st;
endmodule : psg_pin
`default_nettype wire

// file: design/psg_port.sv
`timescale 1ns/1ps
`default_nettype none
// Eight-pin port with LCD segment view, AXI4-Lite slave
module psg_port
  import psg_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [19:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [19:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [2:0]  common_phase,
  input  wire logic [7:0]  pad_i,
  output logic [7:0]       pad_o,
  output logic [7:0]       pad_oe
);
  typedef struct packed {
    logic          aw_got;
    logic          w_got;
    logic [19:0]   awaddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    psg_lcd_cfg_t  lcd;
    logic [63:0]   seg;
    psg_pin_cfg_t [PSG_PINS-1:0] pin;
  } psg_state_t;
  psg_state_t st_r;
  psg_state_t st_nxt;

  logic [7:0] pin_state;
  logic [7:0] seg_level;
  logic [2:0] phase_lim;

  // Phases beyond the duty setting are blanked; duty 0 means 1/8
  always_comb begin
    phase_lim = (st_r.lcd.duty == 3'h0) ? 3'h7 : st_r.lcd.duty;
  end

  genvar gi;
  generate
    for (gi = 0; gi < PSG_PINS; gi++) begin : g_pin
      // Common phase selects one bit of the segment byte
      assign seg_level[gi] = (common_phase <= phase_lim) &
                             st_r.seg[gi*8 + common_phase];
      psg_pin u_pin (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .seg_mode  (st_r.lcd.seg_mode),
        .seg_level (seg_level[gi]),
        .cfg       (st_r.pin[gi]),
        .pad_i     (pad_i[gi]),
        .pad_o     (pad_o[gi]),
        .pad_oe    (pad_oe[gi]),
        .state     (pin_state[gi])
      );
    end
  endgenerate

  // Word index for a port address, or invalid
  function automatic logic [2:0] word_of(input logic [19:0] a);
    logic [2:0] w;
    w = 3'h4;
    case (a)
      PSG_ADDR_PINS01: w = 3'h0;
      PSG_ADDR_PINS23: w = 3'h1;
      PSG_ADDR_PINS45: w = 3'h2;
      PSG_ADDR_PINS67: w = 3'h3;
      default:         w = 3'h4;
    endcase
    return w;
  endfunction : word_of

  // Pin-view field of one pin at a given base bit
  function automatic logic [31:0] pin_field(input psg_pin_cfg_t c, input logic s, input int base);
    logic [31:0] v;
    v = '0;
    v[base + PSG_OE_BIT] = c.oe;
    v[base + PSG_IE_BIT] = c.ie;
    v[base + PSG_DO_BIT] = c.lvl;
    v[base + PSG_DI_BIT] = s;
    return v;
  endfunction : pin_field

  // Read data for a port word under the current view
  function automatic logic [31:0] port_word(input psg_state_t s, input logic [7:0] ps, input logic [1:0] w);
    logic [31:0] v;
    v = '0;
    if (s.lcd.seg_mode) begin
      v[7:0]   = s.seg[{w, 1'b0}*8 +: 8];
      v[23:16] = s.seg[{w, 1'b1}*8 +: 8];
    end else begin
      v = pin_field(s.pin[{w, 1'b0}], ps[{w, 1'b0}], PSG_LO_FIELD) |
          pin_field(s.pin[{w, 1'b1}], ps[{w, 1'b1}], PSG_HI_FIELD);
    end
    return v;
  endfunction : port_word

  // Bus handshakes, register writes and reads
  always_comb begin
    logic [2:0] wi;
    logic [2:0] ri;
    logic       wok;
    wi     = 3'h0;
    ri     = 3'h0;
    wok    = 1'b0;
    st_nxt = st_r;
    if (s_axi_awvalid && !st_r.aw_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_got && !st_r.bvalid) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    // Write commits once both halves are held
    if (st_r.aw_got && st_r.w_got) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      wi            = word_of(st_r.awaddr);
      wok           = 1'b1;
      if (st_r.awaddr == PSG_ADDR_LCDMODE) begin
        if (st_r.wstrb[0]) begin
          st_nxt.lcd.seg_mode = st_r.wdata[0];
          st_nxt.lcd.duty     = st_r.wdata[3:1];
        end
      end else if (wi[2]) begin
        wok = 1'b0;
      end else if (st_r.lcd.seg_mode) begin
        if (st_r.wstrb[0]) st_nxt.seg[{wi[1:0], 1'b0}*8 +: 8] = st_r.wdata[7:0];
        if (st_r.wstrb[2]) st_nxt.seg[{wi[1:0], 1'b1}*8 +: 8] = st_r.wdata[23:16];
      end else begin
        // Input-state bits are read-only; masked bytes are dropped
        if (st_r.wstrb[0]) begin
          st_nxt.pin[{wi[1:0], 1'b0}] = '{oe: st_r.wdata[PSG_OE_BIT], ie: st_r.wdata[PSG_IE_BIT],
                                          lvl: st_r.wdata[PSG_DO_BIT]};
        end
        if (st_r.wstrb[2]) begin
          st_nxt.pin[{wi[1:0], 1'b1}] = '{oe: st_r.wdata[PSG_HI_FIELD + PSG_OE_BIT],
                                          ie: st_r.wdata[PSG_HI_FIELD + PSG_IE_BIT],
                                          lvl: st_r.wdata[PSG_HI_FIELD + PSG_DO_BIT]};
        end
      end
      st_nxt.bresp = wok ? PSG_RESP_OKAY : PSG_RESP_SLVERR;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // Reads answer one cycle after the address is taken
    if (s_axi_arvalid && !st_r.rvalid) begin
      ri            = word_of(s_axi_araddr);
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = PSG_RESP_OKAY;
      st_nxt.rdata  = '0;
      if (s_axi_araddr == PSG_ADDR_LCDMODE) begin
        st_nxt.rdata[3:0] = {st_r.lcd.duty, st_r.lcd.seg_mode};
      end else if (ri[2]) begin
        st_nxt.rresp = PSG_RESP_SLVERR;
      end else begin
        st_nxt.rdata = port_word(st_r, pin_state, ri[1:0]);
      end
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r          <= '0;
      st_r.lcd.duty <= PSG_DUTY_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Ready is a register-free view of the capture and response-valid flags
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rresp   = st_r.rresp;
  assign s_axi_rdata   = st_r.rdata;
endmodule : psg_port
`default_nettype wire

// file: testbench/psg_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Bus and pad timing watcher for the port
module psg_port_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0]  pad_o,
  input wire logic [7:0]  pad_oe
);
  // Single clock domain, so one clocking and one reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RD_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read answer dropped");
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write answer dropped");
  AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken while answering");
  AST_RD_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read taken while answering");
  AST_RSVD_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00 && s_axi_rdata[15:8] == 8'h00)
    else $error("Unused byte not zero");
  AST_RESET_QUIET: assert property ($rose(aresetn) |-> pad_oe == 8'h00 && pad_o == 8'h00)
    else $error("Pads active out of reset");
  // Drivers may only switch as a consequence of a committed write
  // Commit edge loads config, pin flop follows one edge later: bvalid stands then
  AST_PAD_CAUSE: assert property ($changed(pad_oe) |-> $past(s_axi_bvalid, 1) || $past(s_axi_bvalid, 2))
    else $error("Driver enable moved without a write");
endmodule : psg_port_chk
bind psg_port psg_port_chk u_chk (.*);
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import psg_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [19:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp, exp2;
  logic [2:0]  common_phase;
  logic [7:0]  pad_i, pad_o, pad_oe;
  int          err_count, check_count, i, k, ph;
  psg_port u_psg_port (.*);
  // 50 ns period
  always #25 aclk = ~aclk;
  task close_out;
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Bounded wait ran out: count it and stop
  task tmo;
    if (i == 50) begin
      err_count++;
      close_out;
    end
  endtask : tmo
  // Address and data offered together, each released once taken
  task wr(input logic [19:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo;
    @(posedge aclk);
  endtask : wr
  task rd(input logic [19:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo;
    @(posedge aclk);
  endtask : rd
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, common_phase, pad_i} <= '0;
    s_axi_wstrb <= 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // All four port words clear out of reset
    for (k = 0; k < 4; k++) begin
      rd(PSG_ADDR_PINS01 + 20'(k * 4));
      chk("reset word", 32'h00000000, rd_data);
    end
    // Pin 0 drives high, pin 1 drives low; junk in unused lanes
    wr(PSG_ADDR_PINS01, 32'hFF08FF0A);
    chk("bresp", {30'h0, PSG_RESP_OKAY}, {30'h0, resp});
    repeat (4) @(posedge aclk);
    chk("pads", 32'h00000301, {16'h0, pad_oe, pad_o});
    rd(PSG_ADDR_PINS01);
    chk("pins01", 32'h0008000A, rd_data);
    // Every word maps its two pins, all drivers on and low
    for (k = 0; k < 4; k++) wr(PSG_ADDR_PINS01 + 20'(k * 4), 32'h00080008);
    repeat (4) @(posedge aclk);
    chk("all oe", 32'h0000FF00, {16'h0, pad_oe, pad_o});
    // Driver off first, then input on for pin 2 only
    wr(PSG_ADDR_PINS23, 32'h00000000);
    wr(PSG_ADDR_PINS23, 32'h00000004);
    pad_i <= 8'hFF;
    repeat (5) @(posedge aclk);
    rd(PSG_ADDR_PINS23);
    chk("in high", 32'h00000005, rd_data);
    pad_i <= 8'hFB;
    repeat (5) @(posedge aclk);
    rd(PSG_ADDR_PINS23);
    chk("in low", 32'h00000004, rd_data);
    // Unmapped place is refused on both paths
    wr(20'h40860, 32'h00000001);
    chk("wr unmapped", {30'h0, PSG_RESP_SLVERR}, {30'h0, resp});
    rd(20'h40860);
    chk("rd unmapped", {30'h0, PSG_RESP_SLVERR}, {30'h0, resp});
    // Segment view: patterns for segments 0 and 1, every duty code
    wr(PSG_ADDR_LCDMODE, 32'h00000001);
    wr(PSG_ADDR_PINS01, 32'h005A00A5);
    rd(PSG_ADDR_PINS01);
    chk("seg bytes", 32'h005A00A5, rd_data);
    for (k = 0; k < 8; k++) begin
      wr(PSG_ADDR_LCDMODE, 32'(k * 2 + 1));
      for (ph = 0; ph < 8; ph++) begin
        common_phase <= 3'(ph);
        repeat (3) @(posedge aclk);
        exp2 = (ph <= ((k == 0) ? 7 : k)) ? {1'((8'h5A >> ph)), 1'((8'hA5 >> ph))} : 2'h0;
        chk("seg pads", {30'h0, exp2}, {30'h0, pad_o[1:0]});
      end
    end
    rd(PSG_ADDR_LCDMODE);
    chk("mode word", 32'h0000000F, rd_data);
    // Back to pin view, idle pins left as inputs
    wr(PSG_ADDR_LCDMODE, 32'h00000000);
    wr(PSG_ADDR_PINS01, 32'h00040004);
    rd(PSG_ADDR_PINS01);
    chk("idle inputs", 32'h00050005, rd_data);
    close_out;
  end
endmodule : tb_top
`default_nettype wire
